// ===== design/scc_pkg.sv
// Shared constants and types for the simultaneous conversion control block
package scc_pkg;
  localparam int CLK_MHZ = 250;
  localparam int NCH = 8;
  localparam int CODE_W = 16;
  localparam int FIFO_DEPTH = 8;
  // Whole conversion time for all channels, in ns; each channel takes one slot
  localparam int CONV_TIME_NS = 500;
  localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int SLOT_CYC = CONV_CYC / NCH;
  localparam logic [7:0] SLOT_LAST = 8'(SLOT_CYC - 1);
  localparam logic [2:0] CHAN_LAST = 3'h7;
  // Register addresses
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_SPAN_A = 8'h03;
  localparam logic [7:0] ADDR_SPAN_D = 8'h06;
  // Span register layout: two channels per register
  localparam int SPAN_LO_POS = 0;
  localparam int BW_LO_POS = 2;
  localparam int SPAN_HI_POS = 4;
  localparam int BW_HI_POS = 6;
  // Config and status layout
  localparam int CFG_EXTCLK_POS = 0;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_SW_POS = 1;
  localparam int STAT_REF_POS = 2;
  // Reset values
  localparam logic [7:0] SPAN_REG_RST = 8'h22;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  // Span codes
  localparam logic [1:0] SPAN_2V5 = 2'h0;
  localparam logic [1:0] SPAN_5V = 2'h1;
  localparam logic [1:0] SPAN_10V = 2'h2;
  localparam logic [1:0] SPAN_12V5 = 2'h3;
  typedef enum logic [0:0] {ST_IDLE, ST_CONV} scc_state_type;
endpackage : scc_pkg

// ===== design/scc_fifo.sv
// Parameterised result FIFO with valid and ready on both sides
`timescale 1ns/1ns
module scc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] s_data_in,
  input wire logic s_valid_in,
  output logic s_ready_out,
  output logic [WIDTH-1:0] m_data_out,
  output logic m_valid_out,
  input wire logic m_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push_w;
  logic pop_w;

  // Full and empty come from the occupancy count
  assign s_ready_out = (count_q != (AW+1)'(DEPTH));
  assign m_valid_out = (count_q != '0);
  assign m_data_out = mem_q[rd_ptr_q];
  assign push_w = s_valid_in & s_ready_out;
  assign pop_w = m_valid_out & m_ready_in;

  // Storage write
  always_ff @(posedge core_clk_in) begin
    if (push_w) begin
      mem_q[wr_ptr_q] <= s_data_in;
    end
  end

  // Pointers wrap at the depth; count runs from zero up to the depth
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
endmodule : scc_fifo

// ===== design/scc_conv_ctrl.sv
// Conversion control: start handshake, span and reference selection, result readout
// How it works
// R01: Hardware mode: span pin high gives wide span, low narrow, same for all channels.
// R02: Host waits about 80 us after changing the span pin; avoid changes mid-conversion.
// R03: Software mode: per-channel spans come from registers 0x03 to 0x06; pin ignored.
// R04: Start rising edge samples all channels; busy high until all eight are converted.
// R05: Start edges while busy are ignored and never begin a new conversion; with the external clock selected they advance the slot instead.
// R06: New results readable after busy falls; previous ones stay readable during busy.
// R07: All eight channels convert every time and every read carries all eight.
// R08: Each result is a 16-bit two's-complement code.
// R09: Conversions time from the core oscillator, or from the start pin in software mode.
// R10: A per-channel high-bandwidth setting widens the anti-alias filter.
// R11: Reference select high enables the internal reference; low uses the external one.
// R12: After any reset the reference mode follows the select pin at that time. The code tracks the pin continuously, so later pin changes also take effect.
// R13: All three oversampling pins high selects software mode; otherwise hardware mode.
// R14: A read delivers the eight results in ascending order, channel 1 first.
// R15: Host waits for busy to fall before the next start edge.
`timescale 1ns/1ns
module scc_conv_ctrl
  import scc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic conversion_start_pin_in,
  input wire logic range_pin_in,
  input wire logic ref_select_pin_in,
  input wire logic [2:0] oversampling_ratio_pins_in,
  input wire logic [CODE_W-1:0] adc_code_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic read_req_in,
  input wire logic data_ready_in,
  output logic busy_out,
  output logic sample_out,
  output logic [2:0] adc_chan_out,
  output logic [2*NCH-1:0] span_out,
  output logic [NCH-1:0] high_bw_out,
  output logic ref_int_en_out,
  output logic sw_mode_out,
  output logic [7:0] reg_rdata_out,
  output logic [CODE_W-1:0] data_out,
  output logic data_valid_out
);

  // Raw converter code is offset binary from negative full scale
  function automatic logic [CODE_W-1:0] to_twos(input logic [CODE_W-1:0] raw);
    to_twos = {~raw[CODE_W-1], raw[CODE_W-2:0]};
  endfunction : to_twos

  // Pick one channel's bandwidth bit and span field out of its span register
  function automatic logic [2:0] chan_cfg(input logic [7:0] regv, input logic hi);
    chan_cfg = hi ? {regv[BW_HI_POS], regv[SPAN_HI_POS+:2]}
                  : {regv[BW_LO_POS], regv[SPAN_LO_POS+:2]};
  endfunction : chan_cfg

  // Pin synchronisers: start, range, ref select, three oversampling pins
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic start_prev_q;
  logic start_w;
  logic range_w;
  logic ref_w;
  logic [2:0] os_w;
  logic start_rise_w;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      start_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {oversampling_ratio_pins_in, ref_select_pin_in, range_pin_in,
                   conversion_start_pin_in};
      pin_s2_q <= pin_s1_q;
      start_prev_q <= pin_s2_q[0];
    end
  end

  assign start_w = pin_s2_q[0];
  assign range_w = pin_s2_q[1];
  assign ref_w = pin_s2_q[2];
  assign os_w = pin_s2_q[5:3];
  assign start_rise_w = start_w & ~start_prev_q;

  // Registers
  logic [7:0] span_reg_q [4];
  logic [7:0] config_q;
  logic wr_span_w;
  logic [1:0] wr_idx_w;

  assign wr_span_w = reg_wr_in && (reg_addr_in >= ADDR_SPAN_A) && (reg_addr_in <= ADDR_SPAN_D);
  assign wr_idx_w = 2'(reg_addr_in - ADDR_SPAN_A);

  // Register writes; span registers hold values across mode changes
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      span_reg_q <= '{default: SPAN_REG_RST};
      config_q <= CONFIG_RST;
    end else begin
      if (wr_span_w) begin
        span_reg_q[wr_idx_w] <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == ADDR_CONFIG) begin
        config_q <= reg_wdata_in;
      end
    end
  end

  // Mode decode and span selection
  logic sw_mode_w;
  logic ext_clk_w;
  logic [2*NCH-1:0] sw_span_w;
  logic [NCH-1:0] sw_bw_w;
  logic [2*NCH-1:0] hw_span_w;
  logic [2*NCH-1:0] span_d;
  logic [NCH-1:0] high_bw_d;

  assign sw_mode_w = &os_w; // R13
  assign ext_clk_w = sw_mode_w & config_q[CFG_EXTCLK_POS]; // R09
  assign hw_span_w = {NCH{range_w ? SPAN_10V : SPAN_5V}}; // R01

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic [2:0] cfg_w;
    assign cfg_w = chan_cfg(span_reg_q[c/2], 1'(c % 2));
    assign sw_span_w[2*c+:2] = cfg_w[1:0]; // R03
    assign sw_bw_w[c] = cfg_w[2]; // R10
  end

  assign span_d = sw_mode_w ? sw_span_w : hw_span_w; // R03
  assign high_bw_d = sw_mode_w ? sw_bw_w : '0; // R10

  // Configuration outputs, reference follows the synchronised select pin
  logic [2*NCH-1:0] span_q;
  logic [NCH-1:0] high_bw_q;
  logic ref_int_en_q;
  logic sw_mode_q;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      span_q <= '0;
      high_bw_q <= '0;
      ref_int_en_q <= 1'b0;
      sw_mode_q <= 1'b0;
    end else begin
      span_q <= span_d;
      high_bw_q <= high_bw_d;
      ref_int_en_q <= ref_w; // R11 R12
      sw_mode_q <= sw_mode_w;
    end
  end

  // Conversion sequencer: eight slots, one per channel
  scc_state_type state_q;
  logic [7:0] slot_q;
  logic [2:0] chan_q;
  logic sample_q;
  logic tick_w;
  logic start_ok_w;
  logic slot_end_w;
  logic done_w;

  assign tick_w = ext_clk_w ? start_rise_w : 1'b1; // R09
  assign start_ok_w = (state_q == ST_IDLE) && start_rise_w; // R04 R05
  assign slot_end_w = (state_q == ST_CONV) && tick_w && (slot_q == SLOT_LAST);
  assign done_w = slot_end_w && (chan_q == CHAN_LAST); // R07

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      slot_q <= '0;
      chan_q <= '0;
      sample_q <= 1'b0;
    end else begin
      sample_q <= start_ok_w; // R04
      unique case (state_q)
        ST_IDLE: begin
          if (start_ok_w) begin
            state_q <= ST_CONV;
            slot_q <= '0;
            chan_q <= '0;
          end
        end
        ST_CONV: begin
          if (done_w) begin
            state_q <= ST_IDLE; // R04
            chan_q <= '0;
          end else if (slot_end_w) begin
            slot_q <= '0;
            chan_q <= chan_q + 3'h1;
          end else if (tick_w) begin
            slot_q <= slot_q + 8'h01;
          end
        end
      endcase
    end
  end

  // Staging holds the set being converted; bank holds the readable set
  logic [CODE_W-1:0] stage_q [NCH];
  logic [CODE_W-1:0] bank_q [NCH];

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      stage_q <= '{default: '0};
      bank_q <= '{default: '0};
    end else begin
      if (slot_end_w) begin
        stage_q[chan_q] <= to_twos(adc_code_in); // R08
      end
      if (done_w) begin
        bank_q <= stage_q; // R06
        bank_q[CHAN_LAST] <= to_twos(adc_code_in);
      end
    end
  end

  // Readout walks the bank into the FIFO, stalled by FIFO back-pressure
  logic rd_act_q;
  logic [2:0] rd_idx_q;
  logic fifo_s_ready_w;
  logic push_w;

  assign push_w = rd_act_q & fifo_s_ready_w;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rd_act_q <= 1'b0;
      rd_idx_q <= '0;
    end else if (!rd_act_q) begin
      rd_act_q <= read_req_in;
      rd_idx_q <= '0; // R14
    end else if (push_w) begin
      rd_idx_q <= rd_idx_q + 3'h1; // R14
      rd_act_q <= (rd_idx_q != CHAN_LAST); // R07
    end
  end

  logic [CODE_W-1:0] fifo_m_data_w;
  logic fifo_m_valid_w;
  logic pop_w;
  logic [CODE_W-1:0] out_data_q;
  logic out_valid_q;

  assign pop_w = fifo_m_valid_w & (~out_valid_q | data_ready_in);

  scc_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .s_data_in(bank_q[rd_idx_q]),
    .s_valid_in(rd_act_q),
    .s_ready_out(fifo_s_ready_w),
    .m_data_out(fifo_m_data_w),
    .m_valid_out(fifo_m_valid_w),
    .m_ready_in(pop_w)
  );

  // Output register in front of the reader
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop_w) begin
      out_valid_q <= 1'b1;
      out_data_q <= fifo_m_data_w;
    end else if (data_ready_in) begin
      out_valid_q <= 1'b0;
    end
  end

  // Register read mux; unmapped addresses read zero
  logic [7:0] status_w;
  logic [7:0] rdata_w;
  logic rd_span_w;

  assign status_w = (8'(state_q == ST_CONV) << STAT_BUSY_POS)
                  | (8'(sw_mode_q) << STAT_SW_POS)
                  | (8'(ref_int_en_q) << STAT_REF_POS);
  assign rd_span_w = (reg_addr_in >= ADDR_SPAN_A) && (reg_addr_in <= ADDR_SPAN_D);
  assign rdata_w = (reg_addr_in == ADDR_STATUS) ? status_w :
                   (reg_addr_in == ADDR_CONFIG) ? config_q :
                   rd_span_w ? span_reg_q[wr_idx_w] : 8'h00;

  logic [7:0] reg_rdata_q;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_w;
    end
  end

  logic busy_q;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == ST_CONV) ? ~done_w : start_ok_w; // R04
    end
  end

  assign busy_out = busy_q;
  assign sample_out = sample_q;
  assign adc_chan_out = chan_q;
  assign span_out = span_q;
  assign high_bw_out = high_bw_q;
  assign ref_int_en_out = ref_int_en_q;
  assign sw_mode_out = sw_mode_q;
  assign reg_rdata_out = reg_rdata_q;
  assign data_out = out_data_q;
  assign data_valid_out = out_valid_q;

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_start;
    start_ok_w;
  endsequence

  sequence s_busy_hold;
    busy_q [*8];
  endsequence

  busy_rise_a: assert property (s_start |=> busy_q && sample_q) // R04
    else $error("busy or sample missing after start edge");
  busy_hold_a: assert property (s_start ##1 !ext_clk_w |-> s_busy_hold) // R04
    else $error("busy fell too early");
  busy_fall_a: assert property (done_w |=> !busy_q && state_q == ST_IDLE) // R04
    else $error("busy did not fall after last channel");
  no_restart_a: assert property (busy_q && start_rise_w |=> !sample_q) // R05
    else $error("start edge during busy began a conversion");
  bank_hold_a: assert property (busy_q && !done_w |=> $stable(bank_q[0])) // R06
    else $error("readable results changed during busy");
  hw_span_a: assert property (!sw_mode_w |=> span_q == $past(hw_span_w) && high_bw_q == '0) // R01
    else $error("hardware span wrong");
  sw_span_a: assert property (sw_mode_w |=> span_q == $past(sw_span_w)) // R03
    else $error("software span wrong");
  sw_bw_a: assert property (sw_mode_w |=> high_bw_q == $past(sw_bw_w)) // R10
    else $error("bandwidth setting wrong");
  sw_mode_a: assert property (sw_mode_q == $past(sw_mode_w)) // R13
    else $error("mode decode wrong");
  ref_sel_a: assert property (ref_int_en_q == $past(ref_w)) // R11
    else $error("reference select wrong");
  twos_code_a: assert property (slot_end_w && !done_w |=>
                  stage_q[$past(chan_q)] == {~$past(adc_code_in[15]), $past(adc_code_in[14:0])}) // R08
    else $error("result coding wrong");
  read_order_a: assert property (push_w && rd_idx_q != CHAN_LAST |=>
                  rd_act_q && rd_idx_q == $past(rd_idx_q) + 3'h1) // R14
    else $error("readout order wrong");
  read_start_a: assert property (!rd_act_q && read_req_in |=> rd_act_q && rd_idx_q == 3'h0) // R14
    else $error("readout did not start at channel 1");

endmodule : scc_conv_ctrl

// ===== tb/scc_host_model.sv
// Host model: start pin pulses and raw converter codes per channel
`timescale 1ns/1ns
module scc_host_model
  import scc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic go_in,
  input wire logic stray_in,
  input wire logic busy_in,
  input wire logic sample_in,
  input wire logic [2:0] chan_in,
  output logic start_pin_out,
  output logic [CODE_W-1:0] code_out
);
  logic [3:0] set_q;
  logic [2:0] hold_q;
  // Offset-binary code marked with set number and channel
  assign code_out = {set_q, 9'h000, chan_in};
  // Normal starts wait for busy low; stray edges are forced
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      set_q <= 4'h0;
      hold_q <= 3'h0;
      start_pin_out <= 1'b0;
    end else begin
      if (sample_in) begin
        set_q <= set_q + 4'h1;
      end
      start_pin_out <= (hold_q > 3'h1);
      if ((go_in && !busy_in) || stray_in) begin
        hold_q <= 3'h5;
      end else if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end
    end
  end
endmodule : scc_host_model

// ===== tb/tb_top.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ns
module tb_top;
  import scc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic stray = 1'b0;
  logic rng = 1'b0;
  logic refp = 1'b0;
  logic wr = 1'b0;
  logic rreq = 1'b0;
  logic rdy = 1'b0;
  logic [2:0] osp = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic pin, busy, smp, refen, swm, dval;
  logic [2:0] chan;
  logic [15:0] span, code, dout;
  logic [7:0] hbw, rdat;
  int n_errors = 0;
  int samples_checked = 0;
  // Clock, 4 ns period
  always #2 clk = ~clk;
  scc_conv_ctrl i_dut (.core_clk_in(clk), .nrst_in(nrst), .conversion_start_pin_in(pin),
    .range_pin_in(rng), .ref_select_pin_in(refp), .oversampling_ratio_pins_in(osp),
    .adc_code_in(code), .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdat),
    .read_req_in(rreq), .data_ready_in(rdy), .busy_out(busy), .sample_out(smp),
    .adc_chan_out(chan), .span_out(span), .high_bw_out(hbw), .ref_int_en_out(refen),
    .sw_mode_out(swm), .reg_rdata_out(rdat), .data_out(dout), .data_valid_out(dval));
  scc_host_model i_host (.core_clk_in(clk), .nrst_in(nrst), .go_in(go), .stray_in(stray),
    .busy_in(busy), .sample_in(smp), .chan_in(chan), .start_pin_out(pin), .code_out(code));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    cyc(3);
    chk("reg_rdata", 16'(rdat), 16'(exp));
  endtask : rreg
  task automatic pulse(input bit forced);
    @(posedge clk);
    if (forced) stray <= 1'b1;
    else go <= 1'b1;
    @(posedge clk);
    stray <= 1'b0;
    go <= 1'b0;
  endtask : pulse
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk("busy_level", 16'(busy), 16'(lvl));
  endtask : wait_busy
  // Read all eight results, stalling first so the output must hold
  task automatic readout(input logic [3:0] set);
    int i, k;
    @(posedge clk);
    rreq <= 1'b1;
    @(posedge clk);
    rreq <= 1'b0;
    cyc(30);
    chk("held_valid", 16'(dval), 16'h0001);
    chk("held_first", dout, {set, 12'h000} ^ 16'h8000);
    rdy <= 1'b1;
    i = 0;
    k = 0;
    while (i < 8 && k < 60) begin
      @(posedge clk);
      k++;
      if (dval === 1'b1 && rdy === 1'b1) begin
        chk("result", dout, {set, 9'h000, i[2:0]} ^ 16'h8000);
        i++;
      end
    end
    chk("word_count", 16'(i), 16'h0008);
    rdy <= 1'b0;
  endtask : readout
  task automatic t_reset();
    chk("busy_rst", 16'(busy), 16'h0000);
    rreg(ADDR_SPAN_A, SPAN_REG_RST);
    rreg(ADDR_SPAN_D, SPAN_REG_RST);
    rreg(ADDR_CONFIG, CONFIG_RST);
    rreg(8'h07, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_hw();
    osp <= 3'h6;
    rng <= 1'b1;
    cyc(8);
    chk("sw_mode", 16'(swm), 16'h0000);
    chk("span_wide", span, 16'haaaa);
    chk("high_bw", 16'(hbw), 16'h0000);
    chk("range_idle", 16'(busy), 16'h0000);
    rng <= 1'b0;
    refp <= 1'b1;
    cyc(8);
    chk("span_narrow", span, 16'h5555);
    chk("ref_on", 16'(refen), 16'h0001);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(6);
    chk("ref_after_rst", 16'(refen), 16'h0001);
    refp <= 1'b0;
    cyc(8);
    chk("ref_off", 16'(refen), 16'h0000);
    // Let the last span change settle, 80 us, before the first conversion
    cyc(80 * CLK_MHZ);
    $display("t_hw done");
  endtask : t_hw
  task automatic t_conv();
    int n;
    pulse(1'b0);
    wait_busy(1'b1);
    chk("sample_pulse", 16'(smp), 16'h0001);
    n = 1;
    while (busy === 1'b1 && n < 400) begin
      @(posedge clk);
      if (n == 20) begin
        stray <= 1'b1;
        chk("chan_walk", 16'(chan), 16'(20 / SLOT_CYC));
      end
      if (n == 21) stray <= 1'b0;
      if (busy === 1'b1) n++;
    end
    chk("conv_len", 16'(n), 16'(NCH * SLOT_CYC));
    cyc(20);
    chk("stray_ignored", 16'(busy), 16'h0000);
    readout(4'h1);
    pulse(1'b0);
    wait_busy(1'b1);
    readout(4'h1);
    wait_busy(1'b0);
    readout(4'h2);
    $display("t_conv done");
  endtask : t_conv
  task automatic t_sw();
    logic [7:0] v [4] = '{8'h40, 8'h15, 8'h62, 8'h37};
    logic [15:0] es;
    logic [7:0] eb;
    int k;
    osp <= 3'h7;
    cyc(8);
    chk("sw_mode", 16'(swm), 16'h0001);
    for (k = 0; k < 4; k++) begin
      wreg(ADDR_SPAN_A + 8'(k), v[k]);
      es[4*k +: 2] = v[k][1:0];
      es[4*k+2 +: 2] = v[k][5:4];
      eb[2*k] = v[k][2];
      eb[2*k+1] = v[k][6];
    end
    rng <= 1'b1;
    cyc(8);
    chk("sw_span", span, es);
    chk("sw_bw", 16'(hbw), 16'(eb));
    for (k = 0; k < 4; k++) rreg(ADDR_SPAN_A + 8'(k), v[k]);
    rreg(ADDR_STATUS, 8'h02);
    wreg(ADDR_CONFIG, 8'h01);
    pulse(1'b0);
    wait_busy(1'b1);
    cyc(200);
    chk("ext_hold", 16'(busy), 16'h0001);
    k = 0;
    // Each start edge advances the slot count by one, so a set takes a full slot count per channel
    while (busy === 1'b1 && k < NCH * SLOT_CYC + 10) begin
      pulse(1'b1);
      cyc(10);
      k++;
    end
    chk("ext_done", 16'(busy), 16'h0000);
    chk("ext_ticks", 16'(k), 16'(NCH * SLOT_CYC));
    wreg(ADDR_CONFIG, 8'h00);
    $display("t_sw done");
  endtask : t_sw
  // Main sequence
  initial begin
    cyc(16);
    nrst <= 1'b1;
    cyc(2);
    t_reset();
    t_hw();
    t_conv();
    t_sw();
    finish_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    cyc(40000);
    n_errors++;
    finish_test();
  end
endmodule : tb_top
